// ---- dv/pctc_card_ctrl_tb.sv ----
// Self-checking bench for the card transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "pctc_defs.svh"

module pctc_card_ctrl_tb;
    import pctc_pkg::*;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, cardReq, cardDone, cardPresent, cardReadOnly;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] ev, dly;
    logic cardBlk1Exists, optDiff, voltDiff, currDiff, modeDiff, cmpDiff, skipOptMenus, skipRatingParams;
    logic saveToNv, cardWriteInd, bootLoadInd, modeToNv, modeToCard;
    logic [2:0] cardBlk1Type, cardMode;
    logic [9:0] cardBlock;
    pctc_op_type cardOp;
    int n_mismatch = 0, n_tests = 0, nvCnt = 0, loadCnt = 0, cyc = 0, y, n0, i;
    bit sup = 0;
    int codes[9] = '{2001, 4001, 6000, 7000, 8000, 9999, 9666, 9555, 9888};

    pctc_card_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .driveReset(ev[0]), .powerUp(ev[1]), .paramSaved(ev[2]), .menu0Changed(ev[3]),
        .cardPresent(cardPresent), .cardReadOnly(cardReadOnly), .cardDone(cardDone),
        .cardBlk1Exists(cardBlk1Exists), .cardBlk1Type(cardBlk1Type), .cardMode(cardMode), .optDiff(optDiff),
        .voltDiff(voltDiff), .currDiff(currDiff), .modeDiff(modeDiff), .cmpDiff(cmpDiff), .cardOp(cardOp),
        .cardBlock(cardBlock), .cardReq(cardReq), .skipOptMenus(skipOptMenus), .skipRatingParams(skipRatingParams),
        .saveToNv(saveToNv), .cardWriteInd(cardWriteInd), .bootLoadInd(bootLoadInd), .modeToNv(modeToNv),
        .modeToCard(modeToCard));
    pctc_card_model card (.sys_clk(sys_clk), .sys_rst(sys_rst), .cardReq(cardReq), .cardOp(cardOp), .dly(dly),
        .cardDone(cardDone), .cardReadOnly(cardReadOnly));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (saveToNv === 1'b1) nvCnt <= nvCnt + 1;
        if (cardDone === 1'b1 && cardOp === OP_LOAD) loadCnt <= loadCnt + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            summarize();
        end
    end

    task automatic summarize;
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] ex, input string m);
        n_tests++;
        if (got !== ex) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, ex);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int t;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(t, 2, "ready delay");
        @(negedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic er);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk(d, ex, "read data");
        chk({31'h0, e}, {31'h0, er}, "slave error");
    endtask

    task automatic trip(input logic [31:0] ex);
        rd(`PCTC_OFS_TRIP, ex, 1'b0);
        wr(`PCTC_OFS_TRIP, 32'h3f);
    endtask

    task automatic pulse(input int k);
        @(posedge sys_clk) ev[k] <= 1'b1;
        @(posedge sys_clk) ev[k] <= 1'b0;
    endtask

    task automatic waitOp(input pctc_op_type op, input int blk);
        int t;
        t = 0;
        do begin
            @(negedge sys_clk);
            t++;
        end while (!(cardReq === 1'b1 && cardOp === op) && t < 60);
        chk({28'h0, cardOp}, {28'h0, op}, "card op");
        if (blk < 1000) chk({22'h0, cardBlock}, blk, "card block");
    endtask

    task automatic evRun(input int k, input pctc_op_type op, input int blk, input bit pull, input bit ld);
        int t;
        pulse(k);
        waitOp(op, blk);
        if (k == 1) chk({cardWriteInd, bootLoadInd}, op == OP_WR_FULL ? 2 : 1, "indication");
        if (pull) begin
            @(posedge sys_clk) cardPresent <= 1'b0;
            @(posedge sys_clk) cardPresent <= 1'b1;
        end
        if (op == OP_RD_HDR && ld) begin
            waitOp(OP_LOAD, blk);
            chk({skipOptMenus, skipRatingParams}, {optDiff, voltDiff | (currDiff & sup)}, "skip");
        end
        t = 0;
        while (cardReq !== 1'b0 && t < 60) begin
            @(negedge sys_clk);
            t++;
        end
        chk({31'h0, cardReq}, 0, "stuck busy");
    endtask

    // Reference decode: op code in bits 13:10, block in 9:0, 1023 when the block is of no interest
    function automatic int mOp(input int c);
        int d = c / 1000, b = c % 1000;
        if (c == 2001 || c == 4001) return (int'(c == 2001 ? OP_WR_BOOT : OP_WR_DIFF) << 10) | 1;
        if (b != 0 && d >= 6 && d <= 8) return (int'(d == 6 ? OP_RD_HDR : d == 7 ? OP_ERASE : OP_COMPARE) << 10) | b;
        if (c == 9999) return (int'(OP_ERASE_ALL) << 10) | 1023;
        if (c == 9888 || c == 9777) return (int'(c == 9888 ? OP_SET_RO : OP_CLR_RO) << 10) | 1023;
        if (c == 9666 || c == 9555) return -2;
        return -1;
    endfunction

    task automatic cmdRun(input int c);
        int e, n;
        pctc_op_type op;
        logic [31:0] tr;
        e = mOp(c);
        op = e >= 0 ? pctc_op_type'(e[13:10]) : OP_NONE;
        n = nvCnt;
        wr(`PCTC_OFS_CMD, c);
        repeat (3) @(negedge sys_clk);
        chk({31'h0, cardReq}, 0, "early start");
        if (e >= 0)
            evRun(0, op, e[9:0], 1'b0, 1'b1);
        else begin
            pulse(0);
            repeat (4) @(negedge sys_clk);
            chk({31'h0, cardReq}, 0, "no op");
        end
        if (e == -2) sup = (c == 9666);
        tr = 0;
        if (op == OP_RD_HDR) tr[1:0] = {(voltDiff | currDiff) & ~sup, optDiff & ~sup};
        if (op == OP_COMPARE) tr[3] = cmpDiff;
        trip(tr);
        rd(`PCTC_OFS_CMD, (e == -1 || (op == OP_COMPARE && cmpDiff)) ? c : 0, 1'b0);
        if (op == OP_RD_HDR) chk(nvCnt, n + 1, "nv save");
    endtask

    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, ev, cardBlk1Exists, cardBlk1Type, cardMode} = 0;
        {optDiff, voltDiff, currDiff, modeDiff, cmpDiff} = 0;
        cardPresent = 1'b1;
        dly = 4'h2;
        void'($urandom(32'hcc7a));
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 5; i++) rd(12'(i * 4), 0, i == 4);
        foreach (codes[k]) begin
            y = 1 + $urandom % 999;
            cmdRun(codes[k] % 1000 == 0 ? codes[k] + y : codes[k]);
        end
        cmdRun(5001);
        cmdRun(6000);
        rd(`PCTC_OFS_STAT, 32'h1, 1'b0);
        wr(`PCTC_OFS_CMD, 4001);
        pulse(0);
        repeat (4) @(negedge sys_clk);
        chk({31'h0, cardReq}, 0, "protected write");
        trip(32'h10);
        cmdRun(6000 + y);
        cmdRun(9777);
        @(posedge sys_clk) cmpDiff <= 1'b1;
        cmdRun(8000 + y);
        @(posedge sys_clk) cmpDiff <= 1'b0;
        for (i = 0; i < 6; i++) begin
            r = $urandom;
            cmdRun(i % 2 ? 9666 : 9555);
            rd(`PCTC_OFS_STAT, (i % 2) * 2, 1'b0);
            @(posedge sys_clk);
            {optDiff, voltDiff, currDiff} <= r[2:0];
            dly <= {1'b0, r[5:3]};
            cmdRun(6000 + 1 + r[15:6] % 999);
        end
        cmdRun(9555);
        @(posedge sys_clk);
        {optDiff, voltDiff, currDiff} <= 3'h0;
        dly <= 4'h8;
        wr(`PCTC_OFS_MODE, 32'h1);
        n0 = nvCnt;
        evRun(0, OP_RD_HDR, 1, 1'b0, 1'b1);
        rd(`PCTC_OFS_MODE, 0, 1'b0);
        chk(nvCnt, n0 + 1, "nv save");
        wr(`PCTC_OFS_MODE, 32'h2);
        evRun(0, OP_WR_DIFF, 1, 1'b1, 1'b0);
        trip(0);
        rd(`PCTC_OFS_MODE, 0, 1'b0);
        wr(`PCTC_OFS_CMD, 6000 + y);
        evRun(0, OP_RD_HDR, y, 1'b1, 1'b0);
        trip(32'h20);
        wr(`PCTC_OFS_MODE, 32'h3);
        chk({modeToNv, modeToCard}, 2, "mode store");
        evRun(0, OP_WR_FULL, 1024, 1'b0, 1'b0);
        evRun(3, OP_WR_MENU0, 1024, 1'b0, 1'b0);
        evRun(1, OP_WR_FULL, 1024, 1'b0, 1'b0);
        wr(`PCTC_OFS_CMD, 1000);
        n0 = nvCnt;
        evRun(0, OP_WR_FULL, 1024, 1'b0, 1'b0);
        chk(nvCnt, n0 + 1, "save");
        evRun(2, OP_WR_FULL, 1024, 1'b1, 1'b0);
        trip(0);
        rd(`PCTC_OFS_MODE, 0, 1'b0);
        @(posedge sys_clk);
        cardBlk1Exists <= 1'b1;
        cardBlk1Type <= 3'(1 + $urandom % 4);
        cardMode <= `PCTC_MODE_BOOT;
        wr(`PCTC_OFS_MODE, 32'h4);
        chk({modeToNv, modeToCard}, 3, "mode store");
        evRun(1, OP_RD_HDR, 1, 1'b0, 1'b1);
        rd(`PCTC_OFS_MODE, 4, 1'b0);
        @(posedge sys_clk) modeDiff <= 1'b1;
        n0 = loadCnt;
        evRun(1, OP_RD_HDR, 1, 1'b0, 1'b0);
        chk(loadCnt, n0, "boot load");
        trip(32'h4);
        summarize();
    end
endmodule
`default_nettype wire

// ---- dv/pctc_card_model.sv ----
// Behavioural memory card answering the controller's requests
`timescale 1ns/1ps
`default_nettype none

module pctc_card_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cardReq,
    input wire pctc_pkg::pctc_op_type cardOp,
    input wire logic [3:0] dly,
    output logic cardDone,
    output logic cardReadOnly
);
    import pctc_pkg::*;
    logic [3:0] cnt;
    logic fired;
    pctc_op_type lastOp;

    // A changed op code with cardReq held is a fresh request and earns its own answer
    always_ff @(posedge sys_clk) begin
        cardDone <= 1'b0;
        lastOp <= cardOp;
        if (sys_rst || !cardReq || cardOp != lastOp) begin
            cnt <= 4'h0;
            fired <= 1'b0;
        end else if (!fired) begin
            cnt <= cnt + 4'h1;
            if (cnt >= dly) begin
                cardDone <= 1'b1;
                fired <= 1'b1;
                if (cardOp == OP_SET_RO) cardReadOnly <= 1'b1;
                if (cardOp == OP_CLR_RO) cardReadOnly <= 1'b0;
            end
        end
        if (sys_rst) cardReadOnly <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- hw/pctc_card_ctrl.sv ----
// Card command interpreter and cloning mode sequencer with APB register access
// Operation
// - A command code acts only when a drive reset follows.
// - Program mode plus reset writes differences to block one, like 4001.
// - Program action completion clears the cloning mode; block one overwritten silently.
// - Program and auto modes keep all card trips except card swap; code-started transfers such as 1000 in auto mode still raise it.
// - 6yyy loads block yyy into RAM and the non-volatile store.
// - Option category mismatch leaves those menus default and raises option trip.
// - Voltage or current rating difference raises rating trip.
// - Voltage difference skips rating parameters; current-only difference still transfers them.
// - Read mode plus reset loads block one, like 6001.
// - Successful read clears the cloning mode and saves to non-volatile store.
// - Auto mode plus reset writes full clonable parameter set to card.
// - Auto mode updates changed menu zero items; 1000 plus reset saves all.
// - Card removal in auto mode clears the cloning mode.
// - Auto mode: every parameter save also updates the card.
// - Auto mode at power-up writes full set showing card-write indication.
// - Auto mode keeps the cloning mode in own store, not on card.
// - Boot load at power-up needs card, block one, type 1..4, boot.
// - Boot load shows indication; drive mode mismatch trips, transfers nothing.
// - Boot mode stored on card, never copied back into cloning mode.
// - 2001 plus reset makes bootable block one once, overwriting.
// - 8yyy compares; match clears command, mismatch raises compare trip.
// - 7yyy erases block yyy; 9999 erases all blocks.
// - 9666 sets, 9555 clears suppression; suppresses option/rating trips, skips data.
// - Read-only card accepts only 6yyy and 9777; writes trip; 9888 sets.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pctc_defs.svh"

module pctc_card_ctrl (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic driveReset,
    input wire logic powerUp,
    input wire logic paramSaved,
    input wire logic menu0Changed,
    input wire logic cardPresent,
    input wire logic cardReadOnly,
    input wire logic cardDone,
    input wire logic cardBlk1Exists,
    input wire logic [2:0] cardBlk1Type,
    input wire logic [2:0] cardMode,
    input wire logic optDiff,
    input wire logic voltDiff,
    input wire logic currDiff,
    input wire logic modeDiff,
    input wire logic cmpDiff,
    output pctc_pkg::pctc_op_type cardOp,
    output logic [9:0] cardBlock,
    output logic cardReq,
    output logic skipOptMenus,
    output logic skipRatingParams,
    output logic saveToNv,
    output logic cardWriteInd,
    output logic bootLoadInd,
    output logic modeToNv,
    output logic modeToCard
);
    import pctc_pkg::*;

    pctc_regs_type s;
    pctc_regs_type next_s;
    pctc_op_type op;
    logic [9:0] blkv;
    logic hdr;
    logic fromMode;
    logic noSwap;
    logic bootLoad;
    logic [3:0] thou;
    logic [9:0] yyy;
    logic [5:0] tset;
    logic [5:0] tclr;
    logic apbWr;
    logic busy;
    logic isWriteOp;

    assign apbWr = psel & penable & s.rdy & pwrite;
    assign busy = (s.st != ST_IDLE);

    always_comb begin
        next_s = s;
        op = OP_NONE;
        blkv = `PCTC_BLOCK_ONE;
        hdr = 1'b0;
        fromMode = 1'b0;
        noSwap = 1'b0;
        bootLoad = 1'b0;
        tset = '0;
        tclr = '0;
        isWriteOp = 1'b0;
        thou = 4'(s.cmd / `PCTC_CODE_DIV);
        yyy = 10'(s.cmd % `PCTC_CODE_DIV);
        next_s.saveNv = 1'b0;
        next_s.slverr = 1'b0;
        next_s.cardWas = cardPresent;

        if (s.st == ST_IDLE) begin
            if (driveReset && s.cmd != 14'h0000) begin
                // Codes only act on the reset that follows them
                if (s.cmd == `PCTC_CODE_DIFF_WR) begin
                    op = OP_WR_DIFF;
                end else if (s.cmd == `PCTC_CODE_BOOT_WR) begin
                    op = OP_WR_BOOT;
                end else if (s.cmd == `PCTC_CODE_SAVE) begin
                    next_s.saveNv = 1'b1;
                    next_s.cmd = 14'h0000;
                    if (s.mode == `PCTC_MODE_AUTO || s.mode == `PCTC_MODE_BOOT) begin
                        op = OP_WR_FULL;
                    end
                end else if (thou == `PCTC_DIGIT_LOAD && yyy != 10'h000) begin
                    op = OP_LOAD;
                    blkv = yyy;
                    hdr = 1'b1;
                end else if (thou == `PCTC_DIGIT_ERASE && yyy != 10'h000) begin
                    op = OP_ERASE;
                    blkv = yyy;
                end else if (thou == `PCTC_DIGIT_CMP && yyy != 10'h000) begin
                    op = OP_COMPARE;
                    blkv = yyy;
                end else if (s.cmd == `PCTC_CODE_ERASE_ALL) begin
                    op = OP_ERASE_ALL;
                end else if (s.cmd == `PCTC_CODE_RO_SET) begin
                    op = OP_SET_RO;
                end else if (s.cmd == `PCTC_CODE_RO_CLR) begin
                    op = OP_CLR_RO;
                end else if (s.cmd == `PCTC_CODE_SUP_SET && !cardReadOnly) begin
                    next_s.suppress = 1'b1;
                    next_s.cmd = 14'h0000;
                end else if (s.cmd == `PCTC_CODE_SUP_CLR && !cardReadOnly) begin
                    next_s.suppress = 1'b0;
                    next_s.cmd = 14'h0000;
                end
                // Anything else falls through untouched
            end else if (driveReset) begin
                case (s.mode)
                    `PCTC_MODE_READ: begin
                        op = OP_LOAD;
                        hdr = 1'b1;
                        fromMode = 1'b1;
                    end
                    `PCTC_MODE_PROG: begin
                        op = OP_WR_DIFF;
                        fromMode = 1'b1;
                        noSwap = 1'b1;
                    end
                    `PCTC_MODE_AUTO, `PCTC_MODE_BOOT: begin
                        op = OP_WR_FULL;
                        noSwap = 1'b1;
                    end
                    default: begin
                        op = OP_NONE;
                    end
                endcase
            end else if (powerUp && s.mode == `PCTC_MODE_AUTO) begin
                op = OP_WR_FULL;
                noSwap = 1'b1;
                next_s.wrInd = 1'b1;
            end else if (powerUp && s.mode == `PCTC_MODE_BOOT) begin
                if (cardPresent && cardBlk1Exists && cardBlk1Type >= `PCTC_TYPE_MIN
                    && cardBlk1Type <= `PCTC_TYPE_MAX && cardMode == `PCTC_MODE_BOOT) begin
                    op = OP_LOAD;
                    hdr = 1'b1;
                    bootLoad = 1'b1;
                    next_s.bootInd = 1'b1;
                end
            end else if (s.mode == `PCTC_MODE_AUTO || s.mode == `PCTC_MODE_BOOT) begin
                if (paramSaved) begin
                    op = OP_WR_FULL;
                    noSwap = 1'b1;
                end else if (menu0Changed) begin
                    op = OP_WR_MENU0;
                    noSwap = 1'b1;
                end
            end

            isWriteOp = (op != OP_NONE) && (op != OP_LOAD) && (op != OP_CLR_RO);
            // A protected card takes only loads and the unprotect code
            if (cardReadOnly && isWriteOp) begin
                if (op != OP_COMPARE) begin
                    tset[`PCTC_TRIP_RO] = 1'b1;
                end
                op = OP_NONE;
                next_s.wrInd = 1'b0;
            end

            if (op != OP_NONE) begin
                next_s.pend = op;
                next_s.op = hdr ? OP_RD_HDR : op;
                next_s.blk = blkv;
                next_s.req = 1'b1;
                next_s.st = hdr ? ST_HDR : ST_XFER;
                next_s.clrMode = fromMode;
                next_s.clrCmd = (s.cmd != 14'h0000);
                next_s.noSwap = noSwap;
                next_s.isBoot = bootLoad;
                next_s.skipOpt = 1'b0;
                next_s.skipRating = 1'b0;
            end
        end else if (s.st == ST_HDR) begin
            if (cardDone) begin
                if (s.isBoot && modeDiff) begin
                    tset[`PCTC_TRIP_DMODE] = 1'b1;
                    next_s.req = 1'b0;
                    next_s.op = OP_NONE;
                    next_s.st = ST_IDLE;
                    next_s.bootInd = 1'b0;
                end else begin
                    // Mismatched menus stay default either way; only the trip is optional
                    next_s.skipOpt = optDiff;
                    next_s.skipRating = voltDiff | (s.suppress & currDiff);
                    tset[`PCTC_TRIP_OPT] = optDiff & ~s.suppress;
                    tset[`PCTC_TRIP_RATING] = (voltDiff | currDiff) & ~s.suppress;
                    next_s.op = s.pend;
                    next_s.st = ST_XFER;
                end
            end
        end else begin
            if (cardDone) begin
                next_s.req = 1'b0;
                next_s.op = OP_NONE;
                next_s.st = ST_IDLE;
                next_s.wrInd = 1'b0;
                next_s.bootInd = 1'b0;
                next_s.skipOpt = 1'b0;
                next_s.skipRating = 1'b0;
                if (s.op == OP_COMPARE && cmpDiff) begin
                    tset[`PCTC_TRIP_CMP] = 1'b1;
                end else if (s.clrCmd) begin
                    next_s.cmd = 14'h0000;
                end
                if (s.op == OP_LOAD) begin
                    next_s.saveNv = 1'b1;
                end
                if (s.clrMode) begin
                    next_s.mode = `PCTC_MODE_NONE;
                end
            end
        end

        // Card pulled out
        if (s.cardWas && !cardPresent) begin
            if (s.mode == `PCTC_MODE_AUTO) begin
                next_s.mode = `PCTC_MODE_NONE;
            end
            if (busy && !s.noSwap) begin
                tset[`PCTC_TRIP_SWAP] = 1'b1;
            end
        end

        // APB: two-cycle access phase, data registered with pready
        next_s.rdy = psel & penable & ~s.rdy;
        if (psel && penable && !s.rdy) begin
            next_s.slverr = 1'b0;
            case (paddr)
                `PCTC_OFS_CMD: next_s.rdata = {18'h00000, s.cmd};
                `PCTC_OFS_MODE: next_s.rdata = {29'h00000000, s.mode};
                `PCTC_OFS_STAT: next_s.rdata = {27'h0000000, busy, s.bootInd, s.wrInd, s.suppress, cardReadOnly};
                `PCTC_OFS_TRIP: next_s.rdata = {26'h0000000, s.trips};
                default: begin
                    next_s.rdata = 32'h00000000;
                    next_s.slverr = 1'b1;
                end
            endcase
        end
        if (apbWr) begin
            case (paddr)
                `PCTC_OFS_CMD: next_s.cmd = pwdata[13:0];
                `PCTC_OFS_MODE: next_s.mode = pwdata[2:0];
                `PCTC_OFS_TRIP: tclr = pwdata[5:0];
                default: tclr = '0;
            endcase
        end
        // Hardware set beats a software clear in the same cycle
        next_s.trips = (s.trips & ~tclr) | tset;
        // Boot value goes to the card header; loads never write the cloning mode back
        next_s.modeNv = (next_s.mode == `PCTC_MODE_AUTO) | (next_s.mode == `PCTC_MODE_BOOT);
        next_s.modeCard = (next_s.mode == `PCTC_MODE_BOOT);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.op <= OP_NONE;
            s.pend <= OP_NONE;
            s.mode <= `PCTC_MODE_NONE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.rdy;
    assign pslverr = s.slverr;
    assign cardOp = s.op;
    assign cardBlock = s.blk;
    assign cardReq = s.req;
    assign skipOptMenus = s.skipOpt;
    assign skipRatingParams = s.skipRating;
    assign saveToNv = s.saveNv;
    assign cardWriteInd = s.wrInd;
    assign bootLoadInd = s.bootInd;
    assign modeToNv = s.modeNv;
    assign modeToCard = s.modeCard;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_launch_needs_event: assert property ($rose(cardReq) |->
        $past(driveReset) || $past(powerUp) || $past(paramSaved) || $past(menu0Changed))
        else $error("card request without triggering event");

    a_prog_mode_write: assert property ((s.st == ST_IDLE && driveReset && s.cmd == 14'h0000
        && s.mode == `PCTC_MODE_PROG && !cardReadOnly) |=> cardReq && cardOp == OP_WR_DIFF
        && cardBlock == `PCTC_BLOCK_ONE)
        else $error("program mode did not write block one");

    a_prog_mode_clear: assert property ((s.st == ST_XFER && cardDone && s.clrMode && !apbWr)
        |=> s.mode == `PCTC_MODE_NONE && !cardReq)
        else $error("cloning mode not cleared after action");

    a_swap_quiet: assert property ($rose(s.trips[`PCTC_TRIP_SWAP]) |-> !$past(s.noSwap))
        else $error("swap trip raised in program or auto mode");

    a_load_saves_nv: assert property ((s.st == ST_XFER && s.op == OP_LOAD && cardDone)
        |=> saveToNv ##1 !saveToNv)
        else $error("load did not save to store");

    a_option_trip: assert property ((s.st == ST_HDR && cardDone && optDiff && !s.suppress
        && !(s.isBoot && modeDiff)) |=> s.trips[`PCTC_TRIP_OPT] && skipOptMenus && cardOp == OP_LOAD)
        else $error("option mismatch not handled");

    a_rating_skip: assert property ((s.st == ST_HDR && cardDone && !s.isBoot)
        |=> skipRatingParams == ($past(voltDiff) | ($past(s.suppress) & $past(currDiff))))
        else $error("rating skip wrong");

    a_boot_mode_trip: assert property ((s.st == ST_HDR && cardDone && s.isBoot && modeDiff)
        |=> s.trips[`PCTC_TRIP_DMODE] && !cardReq && cardOp == OP_NONE)
        else $error("drive mode mismatch still transferred");

    a_ro_refuse: assert property (($rose(cardReq) && $past(cardReadOnly)) |->
        cardOp == OP_RD_HDR || cardOp == OP_CLR_RO)
        else $error("write reached a read-only card");

    a_ro_write_trip: assert property ((s.st == ST_IDLE && driveReset && cardReadOnly
        && s.cmd == `PCTC_CODE_DIFF_WR) |=> s.trips[`PCTC_TRIP_RO] && !cardReq)
        else $error("protected write did not trip");

    a_suppress_set: assert property ((s.st == ST_IDLE && driveReset && !cardReadOnly && !apbWr
        && s.cmd == `PCTC_CODE_SUP_SET) |=> s.suppress && s.cmd == 14'h0000)
        else $error("suppression flag not set");

    a_power_auto_write: assert property ((s.st == ST_IDLE && powerUp && !driveReset
        && s.mode == `PCTC_MODE_AUTO && !cardReadOnly) |=> cardReq && cardOp == OP_WR_FULL && cardWriteInd)
        else $error("power-up auto write missing");

    a_auto_drop: assert property (($fell(cardPresent) && s.mode == `PCTC_MODE_AUTO && !apbWr)
        |=> s.mode == `PCTC_MODE_NONE)
        else $error("auto mode kept after card removal");

    a_compare_ok: assert property ((s.st == ST_XFER && s.op == OP_COMPARE && cardDone && !cmpDiff
        && s.clrCmd && !apbWr) |=> s.cmd == 14'h0000 && !s.trips[`PCTC_TRIP_CMP] ##0 !cardReq)
        else $error("compare match did not clear command");
endmodule

`default_nettype wire

// ---- hw/pctc_defs.svh ----
// Offsets, codes, field positions and mode values of the card transfer controller
`ifndef PCTC_DEFS_SVH
`define PCTC_DEFS_SVH

`define PCTC_OFS_CMD 12'h000
`define PCTC_OFS_MODE 12'h004
`define PCTC_OFS_STAT 12'h008
`define PCTC_OFS_TRIP 12'h00c

`define PCTC_CODE_SAVE 14'h03e8
`define PCTC_CODE_BOOT_WR 14'h07d1
`define PCTC_CODE_DIFF_WR 14'h0fa1
`define PCTC_CODE_SUP_CLR 14'h2553
`define PCTC_CODE_SUP_SET 14'h25c2
`define PCTC_CODE_RO_CLR 14'h2631
`define PCTC_CODE_RO_SET 14'h26a0
`define PCTC_CODE_ERASE_ALL 14'h270f
`define PCTC_CODE_DIV 14'h03e8
`define PCTC_DIGIT_LOAD 4'h6
`define PCTC_DIGIT_ERASE 4'h7
`define PCTC_DIGIT_CMP 4'h8

`define PCTC_MODE_NONE 3'h0
`define PCTC_MODE_READ 3'h1
`define PCTC_MODE_PROG 3'h2
`define PCTC_MODE_AUTO 3'h3
`define PCTC_MODE_BOOT 3'h4
`define PCTC_TYPE_MIN 3'h1
`define PCTC_TYPE_MAX 3'h4
`define PCTC_BLOCK_ONE 10'h001

`define PCTC_TRIP_OPT 0
`define PCTC_TRIP_RATING 1
`define PCTC_TRIP_DMODE 2
`define PCTC_TRIP_CMP 3
`define PCTC_TRIP_RO 4
`define PCTC_TRIP_SWAP 5
`define PCTC_TRIP_W 6

`endif

// ---- hw/pctc_pkg.sv ----
// Types of the card transfer controller
package pctc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HDR = 3'b010,
        ST_XFER = 3'b100
    } pctc_state_type;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_WR_DIFF = 4'h1, OP_WR_BOOT = 4'h2, OP_WR_FULL = 4'h3,
        OP_WR_MENU0 = 4'h4, OP_RD_HDR = 4'h5, OP_LOAD = 4'h6, OP_COMPARE = 4'h7,
        OP_ERASE = 4'h8, OP_ERASE_ALL = 4'h9, OP_SET_RO = 4'ha, OP_CLR_RO = 4'hb
    } pctc_op_type;

    typedef struct packed {
        pctc_state_type st;
        pctc_op_type op;
        pctc_op_type pend;
        logic [9:0] blk;
        logic req;
        logic [13:0] cmd;
        logic [2:0] mode;
        logic [5:0] trips;
        logic suppress;
        logic skipOpt;
        logic skipRating;
        logic wrInd;
        logic bootInd;
        logic saveNv;
        logic clrMode;
        logic clrCmd;
        logic noSwap;
        logic isBoot;
        logic cardWas;
        logic modeNv;
        logic modeCard;
        logic rdy;
        logic slverr;
        logic [31:0] rdata;
    } pctc_regs_type;
endpackage
